// ===== core/typec_src_pkg.sv
// constants, register map and types for the type-c source port control
package typec_src_pkg;

    // ==========================================================
    // register map (byte addresses on the 32-bit bus)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] SHIFT_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;

    // ==========================================================
    // control register fields
    localparam int CTRL_RANGE_EN_BIT = 0;
    localparam int CTRL_UNDERVOLTAGE_LOCKOUT_EN_BIT = 1;
    localparam int CTRL_OVERVOLTAGE_LOCKOUT_EN_BIT = 2;

    // ==========================================================
    // shift register fields: upper limit in byte 0, lower in byte 1
    localparam int SHIFT_W = 4;
    localparam int SHIFT_HI_LSB = 0;
    localparam int SHIFT_LO_LSB = 8;

    // ==========================================================
    // status register fields
    localparam int ST_ATTACH_BIT = 0;
    localparam int ST_ORIENT_BIT = 1;
    localparam int ST_PWR_EN_BIT = 2;
    localparam int ST_BUS_OK_BIT = 3;
    localparam int ST_ACC_BIT = 4;
    localparam int ST_RP_LSB = 8;

    // ==========================================================
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEBOUNCE_US = 100;
    localparam int POWER_UP_US = 275;
    localparam int ERR_RECOV_US = 25000;
    localparam int DISCHARGE_US = 650;

    // ==========================================================
    // types
    typedef enum logic [1:0] {RP_DEFAULT, RP_MEDIUM, CURRENT_LEVEL_SEL} rp_level_e;
    typedef enum logic [2:0] {ST_UNATT, ST_WAIT, ST_SRC, ST_ACC, ST_ERR} cc_state_e;

endpackage

// ===== core/typec_src_ctrl.sv
// type-c source port control with an axi4-lite register slave
// ==========================================================
// Overview of operation
// - attach pin asserted on sink connection
// - attach pin also asserted for accessories
// - attach state readable in status register
// - default-select low advertises default current
// - default high, level low: medium current
// - both selects high: high current
// - advertised level tracks select pins live
// - accessory pin for audio or debug
// - orientation released for cc1, low cc2
// - orientation readable in status register
// - power path needs sink, bus not over range, and in range after power-up grace
// - power path state readable in status
// - optional lockouts further qualify power path
// - over-range at sink attach withholds connection
// - over-range after sink attach, or out-of-range after power-up grace, forces error recovery
// - upper limit shift one to fifteen percent
// - lower limit shift one to fifteen percent
// - shift defaults loaded from nonvolatile straps
// - each limit changeable by nvm or software
// - classify partner as sink or accessory
// - three current capability levels
// - status pins are active-low open drain
// - bus-ok pin asserted when attached in range
// - discharge on sink detach and error recovery
// - reset input is active high
`timescale 1ns/1ps

module typec_src_ctrl #(
    parameter int DEBOUNCE_CYC = typec_src_pkg::DEBOUNCE_US * 1000 / typec_src_pkg::CLK_PERIOD_NS,
    parameter int POWER_UP_CYC = typec_src_pkg::POWER_UP_US * 1000 / typec_src_pkg::CLK_PERIOD_NS,
    parameter int ERR_RECOV_CYC = typec_src_pkg::ERR_RECOV_US * 1000 / typec_src_pkg::CLK_PERIOD_NS,
    parameter int DISCHARGE_CYC = typec_src_pkg::DISCHARGE_US * 1000 / typec_src_pkg::CLK_PERIOD_NS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // cc line comparator results
    input wire logic cc1_rd_i,
    input wire logic cc1_ra_i,
    input wire logic cc2_rd_i,
    input wire logic cc2_ra_i,
    // bus voltage monitor results
    input wire logic bus_power_sense_i,
    input wire logic bus_above_hi_i,
    input wire logic bus_below_lo_i,
    input wire logic undervoltage_lockout_i,
    input wire logic overvoltage_lockout_i,
    // current select pins
    input wire logic default_current_sel_i,
    input wire logic current_level_sel_i,
    // nonvolatile defaults and reprogramming strobe
    input wire logic [3:0] nvm_hi_shift_i,
    input wire logic [3:0] nvm_lo_shift_i,
    input wire logic [2:0] nvm_ctrl_i,
    input wire logic nvm_load_i,
    // analog side controls
    output logic [1:0] rp_level_o,
    output logic [3:0] hi_shift_o,
    output logic [3:0] lo_shift_o,
    output logic discharge_en_o,
    // open-drain status pins
    output logic attach_n_o,
    output logic attach_n_oe_o,
    output logic accessory_found_n_o,
    output logic accessory_found_n_oe_o,
    output logic orientation_n_o,
    output logic orientation_n_oe_o,
    output logic power_path_en_n_o,
    output logic power_path_en_n_oe_o,
    output logic bus_power_ok_n_o,
    output logic bus_power_ok_n_oe_o
);

    initial begin
        if (DEBOUNCE_CYC < 1 || POWER_UP_CYC < 1 || ERR_RECOV_CYC < 1 || DISCHARGE_CYC < 1) begin
            $error("timing counts must be at least one cycle");
        end
    end

    // ==========================================================
    // input synchronisers
    localparam int NSYNC = 11;
    logic [NSYNC-1:0] async_w;
    logic [NSYNC-1:0] meta_r;
    logic [NSYNC-1:0] sync_r;

    assign async_w = {current_level_sel_i, default_current_sel_i, overvoltage_lockout_i,
                      undervoltage_lockout_i, bus_below_lo_i, bus_above_hi_i, bus_power_sense_i,
                      cc2_ra_i, cc2_rd_i, cc1_ra_i, cc1_rd_i};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_w;
            sync_r <= meta_r;
        end
    end

    wire cc1_rd_s = sync_r[0];
    wire cc1_ra_s = sync_r[1];
    wire cc2_rd_s = sync_r[2];
    wire cc2_ra_s = sync_r[3];
    wire present_s = sync_r[4];
    wire above_s = sync_r[5];
    wire below_s = sync_r[6];
    wire undervoltage_lockout_s = sync_r[7];
    wire overvoltage_lockout_s = sync_r[8];
    wire def_sel_s = sync_r[9];
    wire lvl_sel_s = sync_r[10];

    // ==========================================================
    // configuration registers
    logic [2:0] ctrl_r;
    logic [3:0] hi_shift_r;
    logic [3:0] lo_shift_r;
    logic loaded_r;

    // ==========================================================
    // axi4-lite write path: address and data taken in either order
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;

    wire aw_take = s_axi_awvalid_i && s_axi_awready_o;
    wire w_take = s_axi_wvalid_i && s_axi_wready_o;
    wire wr_go = aw_held_r && w_held_r && !bvalid_r;
    wire wr_ctrl = wr_go && awaddr_r == typec_src_pkg::CTRL_OFS;
    wire wr_shift = wr_go && awaddr_r == typec_src_pkg::SHIFT_OFS;
    wire wr_status = wr_go && awaddr_r == typec_src_pkg::STATUS_OFS;
    wire wr_hit = wr_ctrl || wr_shift || wr_status;

    assign s_axi_awready_o = !aw_held_r;
    assign s_axi_wready_o = !w_held_r;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= typec_src_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_r <= 1'b1;
                awaddr_r <= {s_axi_awaddr_i[7:2], 2'h0};
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata_i;
                wstrb_r <= s_axi_wstrb_i;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                // status is read-only: writes there are dropped quietly
                bresp_r <= wr_hit ? typec_src_pkg::RESP_OKAY : typec_src_pkg::RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready_i) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // configuration: straps after reset, reload strobe, software writes
    wire nvm_go = !loaded_r || nvm_load_i;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            loaded_r <= 1'b0;
            ctrl_r <= '0;
            hi_shift_r <= '0;
            lo_shift_r <= '0;
        end else begin
            loaded_r <= 1'b1;
            if (nvm_go) begin
                ctrl_r <= nvm_ctrl_i;
                hi_shift_r <= nvm_hi_shift_i;
                lo_shift_r <= nvm_lo_shift_i;
            end
            if (wr_ctrl && wstrb_r[0]) begin
                ctrl_r <= wdata_r[2:0];
            end
            if (wr_shift && wstrb_r[0]) begin
                hi_shift_r <= wdata_r[typec_src_pkg::SHIFT_HI_LSB +: typec_src_pkg::SHIFT_W];
            end
            if (wr_shift && wstrb_r[1]) begin
                lo_shift_r <= wdata_r[typec_src_pkg::SHIFT_LO_LSB +: typec_src_pkg::SHIFT_W];
            end
        end
    end

    // the analog comparators apply the shift code in percent
    assign hi_shift_o = hi_shift_r;
    assign lo_shift_o = lo_shift_r;

    // ==========================================================
    // partner classification
    wire range_en = ctrl_r[typec_src_pkg::CTRL_RANGE_EN_BIT];
    wire undervoltage_lockout_en = ctrl_r[typec_src_pkg::CTRL_UNDERVOLTAGE_LOCKOUT_EN_BIT];
    wire overvoltage_lockout_en = ctrl_r[typec_src_pkg::CTRL_OVERVOLTAGE_LOCKOUT_EN_BIT];

    wire debug_acc = cc1_rd_s && cc2_rd_s;
    wire audio_acc = cc1_ra_s && cc2_ra_s;
    wire acc_seen = debug_acc || audio_acc;
    wire sink_seen = (cc1_rd_s ^ cc2_rd_s) && !acc_seen;
    wire cc2_side = cc2_rd_s && !cc1_rd_s;
    wire over_s = range_en && above_s;
    wire under_s = range_en ? below_s : !present_s;
    wire in_range = present_s && !over_s && !under_s;
    wire lockout_ok = !(undervoltage_lockout_en && undervoltage_lockout_s) && !(overvoltage_lockout_en && overvoltage_lockout_s);

    // ==========================================================
    // source-role state machine
    typec_src_pkg::cc_state_e state_r;
    typec_src_pkg::cc_state_e state_nxt;
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic orient_r;
    logic orient_nxt;

    wire cnt_db_done = cnt_r >= 32'(DEBOUNCE_CYC);
    wire cnt_pu_done = cnt_r >= 32'(POWER_UP_CYC);
    wire cnt_err_done = cnt_r >= 32'(ERR_RECOV_CYC);
    wire bus_fault = over_s || (cnt_pu_done && !in_range);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 32'h1;
        orient_nxt = orient_r;
        unique case (state_r)
            typec_src_pkg::ST_UNATT: begin
                cnt_nxt = '0;
                if (sink_seen || acc_seen) begin
                    state_nxt = typec_src_pkg::ST_WAIT;
                end
            end
            typec_src_pkg::ST_WAIT: begin
                if (!sink_seen && !acc_seen) begin
                    state_nxt = typec_src_pkg::ST_UNATT;
                end else if (cnt_db_done) begin
                    cnt_nxt = cnt_r;
                    if (acc_seen) begin
                        state_nxt = typec_src_pkg::ST_ACC;
                        cnt_nxt = '0;
                    end else if (!over_s) begin
                        // a bus already over the upper limit holds us here
                        state_nxt = typec_src_pkg::ST_SRC;
                        orient_nxt = cc2_side;
                        cnt_nxt = '0;
                    end
                end
            end
            typec_src_pkg::ST_SRC: begin
                // counter saturates once the power-up grace has passed
                if (cnt_pu_done) begin
                    cnt_nxt = cnt_r;
                end
                if (!sink_seen) begin
                    state_nxt = typec_src_pkg::ST_UNATT;
                end else if (bus_fault) begin
                    state_nxt = typec_src_pkg::ST_ERR;
                    cnt_nxt = '0;
                end
            end
            typec_src_pkg::ST_ACC: begin
                cnt_nxt = '0;
                if (!acc_seen) begin
                    state_nxt = typec_src_pkg::ST_UNATT;
                end
            end
            typec_src_pkg::ST_ERR: begin
                if (cnt_err_done) begin
                    state_nxt = typec_src_pkg::ST_UNATT;
                    cnt_nxt = '0;
                end
            end
            default: begin
                state_nxt = typec_src_pkg::ST_UNATT;
                cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= typec_src_pkg::ST_UNATT;
            cnt_r <= '0;
            orient_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            orient_r <= orient_nxt;
        end
    end

    // ==========================================================
    // discharge timer: started on detach from a powered state
    logic [31:0] dis_cnt_r;
    wire detach_ev = state_r == typec_src_pkg::ST_SRC && state_nxt == typec_src_pkg::ST_UNATT;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dis_cnt_r <= '0;
        end else if (detach_ev) begin
            dis_cnt_r <= 32'(DISCHARGE_CYC);
        end else if (dis_cnt_r != '0) begin
            dis_cnt_r <= dis_cnt_r - 32'h1;
        end
    end

    // ==========================================================
    // registered pin and level outputs
    logic attach_r;
    logic acc_r;
    logic orient_pin_r;
    logic pwr_en_r;
    logic bus_ok_r;
    logic discharge_r;
    logic [1:0] rp_r;

    wire is_src = state_r == typec_src_pkg::ST_SRC;
    wire is_acc = state_r == typec_src_pkg::ST_ACC;
    wire [1:0] rp_w = !def_sel_s ? 2'(typec_src_pkg::RP_DEFAULT)
                    : (lvl_sel_s ? 2'(typec_src_pkg::CURRENT_LEVEL_SEL) : 2'(typec_src_pkg::RP_MEDIUM));

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            attach_r <= 1'b0;
            acc_r <= 1'b0;
            orient_pin_r <= 1'b0;
            pwr_en_r <= 1'b0;
            bus_ok_r <= 1'b0;
            discharge_r <= 1'b0;
            rp_r <= 2'(typec_src_pkg::RP_DEFAULT);
        end else begin
            attach_r <= is_src || is_acc;
            acc_r <= is_acc;
            orient_pin_r <= is_src && orient_r;
            pwr_en_r <= is_src && !bus_fault && lockout_ok;
            bus_ok_r <= (is_src || is_acc) && in_range;
            discharge_r <= state_r == typec_src_pkg::ST_ERR || dis_cnt_r != '0 || detach_ev;
            rp_r <= rp_w;
        end
    end

    // open drain: data always low, enable when asserted
    assign attach_n_o = 1'b0;
    assign attach_n_oe_o = attach_r;
    assign accessory_found_n_o = 1'b0;
    assign accessory_found_n_oe_o = acc_r;
    assign orientation_n_o = 1'b0;
    assign orientation_n_oe_o = orient_pin_r;
    assign power_path_en_n_o = 1'b0;
    assign power_path_en_n_oe_o = pwr_en_r;
    assign bus_power_ok_n_o = 1'b0;
    assign bus_power_ok_n_oe_o = bus_ok_r;
    assign discharge_en_o = discharge_r;
    assign rp_level_o = rp_r;

    // ==========================================================
    // axi4-lite read path
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [31:0] status_w;

    always_comb begin
        status_w = '0;
        status_w[typec_src_pkg::ST_ATTACH_BIT] = attach_r;
        status_w[typec_src_pkg::ST_ORIENT_BIT] = orient_pin_r;
        status_w[typec_src_pkg::ST_PWR_EN_BIT] = pwr_en_r;
        status_w[typec_src_pkg::ST_BUS_OK_BIT] = bus_ok_r;
        status_w[typec_src_pkg::ST_ACC_BIT] = acc_r;
        status_w[typec_src_pkg::ST_RP_LSB +: 2] = rp_r;
    end

    wire [7:0] rd_addr = {s_axi_araddr_i[7:2], 2'h0};
    wire rd_ctrl = rd_addr == typec_src_pkg::CTRL_OFS;
    wire rd_shift = rd_addr == typec_src_pkg::SHIFT_OFS;
    wire rd_status = rd_addr == typec_src_pkg::STATUS_OFS;
    wire [31:0] shift_w = {20'h0, lo_shift_r, 4'h0, hi_shift_r};
    wire [31:0] rd_mux = rd_ctrl ? {29'h0, ctrl_r} : rd_shift ? shift_w : rd_status ? status_w : 32'h0;
    wire ar_take = s_axi_arvalid_i && s_axi_arready_o;

    assign s_axi_arready_o = !rvalid_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rdata_o = rdata_r;
    assign s_axi_rresp_o = rresp_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= typec_src_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= (rd_ctrl || rd_shift || rd_status) ? typec_src_pkg::RESP_OKAY : typec_src_pkg::RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready_i) begin
            rvalid_r <= 1'b0;
        end
    end

    // ==========================================================
    // assertions
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_ATTACH_SRC: assert property (is_src |=> attach_n_oe_o)
        else $error("attach pin not asserted for sink");
    AST_ATTACH_ACC: assert property (is_acc |=> attach_n_oe_o && accessory_found_n_oe_o)
        else $error("accessory attach not shown on pins");
    AST_STATUS_ATTACH: assert property (status_w[0] == attach_n_oe_o && status_w[2] == power_path_en_n_oe_o)
        else $error("status bits differ from pins");
    AST_RP_DEFAULT: assert property (!def_sel_s |=> rp_level_o == 2'(typec_src_pkg::RP_DEFAULT))
        else $error("default current not advertised");
    AST_CURRENT_LEVEL_SEL: assert property (def_sel_s && lvl_sel_s |=> rp_level_o == 2'(typec_src_pkg::CURRENT_LEVEL_SEL))
        else $error("high current not advertised");
    AST_RP_FOLLOW: assert property ($rose(def_sel_s) |=> rp_level_o != 2'(typec_src_pkg::RP_DEFAULT))
        else $error("advertised level did not follow select pin");
    AST_ORIENT: assert property (is_src && orient_r |=> orientation_n_oe_o)
        else $error("orientation pin not low for cc2");
    AST_PWR_QUAL: assert property (power_path_en_n_oe_o |-> $past(is_src) && $past(lockout_ok) && !$past(over_s))
        else $error("power path enabled without qualification");
    AST_WITHHOLD: assert property (state_r == typec_src_pkg::ST_WAIT && over_s |=> !is_src)
        else $error("connection made with bus out of range");
    AST_FAULT_RECOVER: assert property (is_src && sink_seen && over_s |=> state_r == typec_src_pkg::ST_ERR ##1
                                        !power_path_en_n_oe_o && !attach_n_oe_o && discharge_en_o)
        else $error("bus fault did not force error recovery");
    AST_DISCHARGE_ERR: assert property (state_r == typec_src_pkg::ST_ERR |=> discharge_en_o)
        else $error("no discharge in error recovery");
    AST_LOAD_NVM: assert property ($rose(loaded_r) |-> hi_shift_r == $past(nvm_hi_shift_i))
        else $error("straps not loaded after reset");

endmodule

// ===== verif/typec_sink_model.sv
// terminations that a sink or an accessory presents across the cable
`timescale 1ns/1ps

module typec_sink_model (
    input wire logic [2:0] mode_i,
    output logic cc1_rd_o,
    output logic cc1_ra_o,
    output logic cc2_rd_o,
    output logic cc2_ra_o
);
    // ==========================================================
    // modes: 0 open, 1 sink on cc1, 2 sink on cc2, 3 audio, 4 debug
    assign cc1_rd_o = (mode_i == 3'h1) || (mode_i == 3'h4);
    assign cc2_rd_o = (mode_i == 3'h2) || (mode_i == 3'h4);
    assign cc1_ra_o = (mode_i == 3'h3);
    assign cc2_ra_o = (mode_i == 3'h3);
endmodule

// ===== verif/typec_src_ctrl_tb.sv
// self-checking bench for the type-c source port control
`timescale 1ns/1ps

module typec_src_ctrl_tb;
    // ==========================================================
    // stimulus, observed outputs and instances
    logic clk_i = 1'b0, rst_i = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, d;
    logic [3:0] strb = 4'h0, nhi = 4'h3, nlo = 4'h5;
    logic [2:0] mode = 3'h0, nctl = 3'h1;
    logic sense = 1'b1, above = 1'b0, undervoltage_lockout = 1'b0, dsel = 1'b0, lsel = 1'b0;
    logic below = 1'b0, overvoltage_lockout = 1'b0, nld = 1'b0;
    logic awr, wr, bv, arr, rv, dis, c1d, c1a, c2d, c2a;
    logic [1:0] bresp, rresp, rp;
    logic [31:0] rdata;
    logic [3:0] hs, ls;
    logic [4:0] pin, oe;
    logic [1:0] rpx [4];
    int bad_count = 0, n_compared = 0;
    typec_sink_model sink (.mode_i(mode), .cc1_rd_o(c1d), .cc1_ra_o(c1a), .cc2_rd_o(c2d), .cc2_ra_o(c2a));
    typec_src_ctrl #(.DEBOUNCE_CYC(4), .POWER_UP_CYC(8), .ERR_RECOV_CYC(10), .DISCHARGE_CYC(5)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .cc1_rd_i(c1d), .cc1_ra_i(c1a), .cc2_rd_i(c2d),
        .cc2_ra_i(c2a), .bus_power_sense_i(sense), .bus_above_hi_i(above), .bus_below_lo_i(below),
        .undervoltage_lockout_i(undervoltage_lockout), .overvoltage_lockout_i(overvoltage_lockout), .default_current_sel_i(dsel),
        .current_level_sel_i(lsel), .nvm_hi_shift_i(nhi), .nvm_lo_shift_i(nlo), .nvm_ctrl_i(nctl),
        .nvm_load_i(nld), .rp_level_o(rp), .hi_shift_o(hs), .lo_shift_o(ls), .discharge_en_o(dis),
        .attach_n_o(pin[0]), .attach_n_oe_o(oe[0]), .orientation_n_o(pin[1]), .orientation_n_oe_o(oe[1]),
        .power_path_en_n_o(pin[2]), .power_path_en_n_oe_o(oe[2]), .bus_power_ok_n_o(pin[3]),
        .bus_power_ok_n_oe_o(oe[3]), .accessory_found_n_o(pin[4]), .accessory_found_n_oe_o(oe[4]));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic drv(input logic [2:0] m, input logic ab);
        @(posedge clk_i);
        mode <= m;
        above <= ab;
    endtask

    // bready held from the start; payload released only at the edge that took it
    task automatic wrr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic ta, tw, done;
        logic [1:0] r;
        done = 1'b0;
        @(posedge clk_i);
        awaddr <= a; wdata <= v; strb <= 4'hF; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge clk_i);
            ta = awv && awr; tw = wv && wr; done = bv; r = bresp;
            @(posedge clk_i);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        br <= 1'b0;
        chk({31'h0, done}, 32'h1);
        chk(32'(r), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
        logic ta, done;
        logic [1:0] r;
        done = 1'b0;
        @(posedge clk_i);
        araddr <= a; arv <= 1'b1; rr <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge clk_i);
            ta = arv && arr; done = rv; r = rresp; v = rdata;
            @(posedge clk_i);
            if (ta) arv <= 1'b0;
        end
        rr <= 1'b0;
        chk({31'h0, done}, 32'h1);
        chk(32'(r), 32'(er));
    endtask

    // pins and status word agree: attach, orient, power, bus ok, accessory, then level
    task automatic pst(input logic [4:0] e, input logic [1:0] lv);
        chk(32'(oe), 32'(e));
        rd(typec_src_pkg::STATUS_OFS, d, typec_src_pkg::RESP_OKAY);
        chk(d, 32'(e) | (32'(lv) << typec_src_pkg::ST_RP_LSB));
    endtask

    task automatic tally_and_finish();
        $display("compared=%0d mismatches=%0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #100000;
        bad_count++;
        tally_and_finish();
    end

    // ==========================================================
    // tests
    initial begin
        rpx = '{typec_src_pkg::RP_DEFAULT, typec_src_pkg::RP_DEFAULT, typec_src_pkg::RP_MEDIUM,
                typec_src_pkg::CURRENT_LEVEL_SEL};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(32'(oe), 32'h0);
        rd(typec_src_pkg::CTRL_OFS, d, typec_src_pkg::RESP_OKAY);
        chk(d, 32'h1);
        rd(typec_src_pkg::SHIFT_OFS, d, typec_src_pkg::RESP_OKAY);
        chk(d, 32'h503);
        chk({hs, ls}, 8'h35);
        wrr(typec_src_pkg::SHIFT_OFS, 32'hF01, typec_src_pkg::RESP_OKAY);
        rd(typec_src_pkg::SHIFT_OFS, d, typec_src_pkg::RESP_OKAY);
        chk(d, 32'hF01);
        chk({hs, ls}, 8'h1F);
        @(posedge clk_i);
        nld <= 1'b1;
        @(posedge clk_i);
        nld <= 1'b0;
        wt(1);
        chk({hs, ls}, 8'h35);
        rd(8'h0C, d, typec_src_pkg::RESP_SLVERR);
        wrr(8'h10, 32'h7, typec_src_pkg::RESP_SLVERR);
        wrr(typec_src_pkg::STATUS_OFS, 32'hFFFF, typec_src_pkg::RESP_OKAY);
        pst(5'h00, 2'h0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            {dsel, lsel} <= i[1:0];
            wt(5);
            pst(5'h00, rpx[i]);
        end
        $display("test config done");
        drv(3'h1, 1'b0);
        wt(20);
        pst(5'b01101, 2'h2);
        chk(32'(pin), 32'h0);
        @(posedge clk_i);
        dsel <= 1'b0;
        wt(5);
        chk(32'(rp), 32'(typec_src_pkg::RP_DEFAULT));
        drv(3'h1, 1'b1);
        wt(5);
        chk({27'h0, dis, oe[2:0]}, 32'h8);
        drv(3'h0, 1'b0);
        wt(30);
        drv(3'h2, 1'b0);
        wt(20);
        pst(5'b01111, 2'h0);
        drv(3'h0, 1'b0);
        wt(5);
        chk({31'h0, dis}, 32'h1);
        wt(15);
        chk({31'h0, dis}, 32'h0);
        $display("test sink done");
        for (int m = 3; m < 5; m++) begin
            drv(m[2:0], 1'b0);
            wt(20);
            chk({oe[4], oe[0]}, 2'h3);
            drv(3'h0, 1'b0);
            wt(20);
        end
        drv(3'h1, 1'b1);
        wt(20);
        chk(32'(oe), 32'h0);
        drv(3'h1, 1'b0);
        wt(20);
        chk({31'h0, oe[0]}, 32'h1);
        drv(3'h0, 1'b0);
        wt(20);
        wrr(typec_src_pkg::CTRL_OFS, 32'h3, typec_src_pkg::RESP_OKAY);
        @(posedge clk_i);
        undervoltage_lockout <= 1'b1;
        drv(3'h1, 1'b0);
        wt(20);
        pst(5'b01001, 2'h0);
        @(posedge clk_i);
        undervoltage_lockout <= 1'b0;
        wt(5);
        chk({31'h0, oe[2]}, 32'h1);
        $display("test faults done");
        tally_and_finish();
    end
endmodule
